// ===== udw_host.sv
// Host sequencer driving the select, direction and step pins of the wiper.
`timescale 1ns/100ps
`default_nettype none
module udw_host
  import udw_pkg::*;
#(
  // Store deselect wait in cycles, shortened in simulation.
  parameter int STORE_WAIT_CYC = CYC_DESEL_STORE,
  parameter int N_STEPS_W = STEPS_W
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Command port.
  input wire logic i_cmd_valid,
  input wire udw_cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_done,
  // Tracked wiper position, loaded by user after power-up recall.
  input wire logic i_pos_load,
  input wire logic [POS_W-1:0] i_pos,
  output logic [POS_W-1:0] o_pos,
  // Device pins.
  output udw_pins_t o_pins
);
  udw_state_t state_ff;
  udw_state_t nxt_state;
  udw_cmd_t cmd_ff;
  udw_cmd_t nxt_cmd;
  logic [N_STEPS_W-1:0] left_ff;
  logic [N_STEPS_W-1:0] nxt_left;
  udw_pins_t pins_ff;
  udw_pins_t nxt_pins;
  logic [POS_W-1:0] pos_ff;
  logic [POS_W-1:0] nxt_pos;
  logic ready_ff;
  logic nxt_ready;
  logic done_ff;
  logic nxt_done;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic tmr_done;

  // Shared wait timer for every phase of the pin sequence.
  udw_timer #(
    .W(TMR_W)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_load(tmr_load),
    .i_count(tmr_count),
    .o_done(tmr_done)
  );

  // Sequencer: idle takes a command; each later state moves on done, and all but desel load the next wait.
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_left = left_ff;
    nxt_pins = pins_ff;
    nxt_pos = pos_ff;
    nxt_ready = 1'b0;
    nxt_done = 1'b0;
    tmr_load = 1'b0;
    tmr_count = '0;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_ready = 1'b1;
        if (i_pos_load)
        begin
          nxt_pos = i_pos;
        end
        if (ready_ff && i_cmd_valid)
        begin
          nxt_ready = 1'b0;
          nxt_cmd = i_cmd;
          nxt_left = N_STEPS_W'(i_cmd.steps);
          // Select only with step high, so selecting never moves it.
          nxt_pins.step = 1'b1;
          nxt_pins.up = i_cmd.up;
          nxt_state = ST_SEL;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_DIR_SETUP);
        end
      end
      ST_SEL:
      begin
        // Direction settles while still deselected, then select drops.
        if (tmr_done)
        begin
          nxt_pins.sel_n = 1'b0;
          nxt_state = ST_DIR;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(CYC_SEL_SETUP);
        end
      end
      ST_DIR:
      begin
        if (tmr_done)
        begin
          if (left_ff == '0)
          begin
            nxt_state = ST_ENDPHASE;
            tmr_load = 1'b1;
            tmr_count = TMR_W'(CYC_STEP_TO_DESEL);
          end
          else
          begin
            nxt_pins.step = 1'b0;
            nxt_state = ST_LOW;
            tmr_load = 1'b1;
            tmr_count = TMR_W'(CYC_STEP_LOW);
            // Track the device counter, which saturates at its ends.
            if (cmd_ff.up && pos_ff != POS_MAX)
            begin
              nxt_pos = pos_ff + POS_W'(1);
            end
            else if (!cmd_ff.up && pos_ff != POS_MIN)
            begin
              nxt_pos = pos_ff - POS_W'(1);
            end
          end
        end
      end
      ST_LOW:
      begin
        if (tmr_done)
        begin
          nxt_left = left_ff - N_STEPS_W'(1);
          if (left_ff == N_STEPS_W'(1) && !cmd_ff.store)
          begin
            // Keep step low for the final deselect: no store.
            nxt_state = ST_ENDPHASE;
            tmr_load = 1'b1;
            tmr_count = TMR_W'(CYC_STEP_TO_DESEL);
          end
          else
          begin
            nxt_pins.step = 1'b1;
            nxt_state = ST_HIGH;
            tmr_load = 1'b1;
            tmr_count = TMR_W'(CYC_STEP_HIGH);
          end
        end
      end
      ST_HIGH:
      begin
        if (tmr_done)
        begin
          nxt_state = ST_DIR;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(1);
        end
      end
      ST_ENDPHASE:
      begin
        // Step level here decides store (high) or no store (low).
        if (tmr_done)
        begin
          nxt_pins.sel_n = 1'b1;
          nxt_state = ST_DESEL;
          tmr_load = 1'b1;
          tmr_count = pins_ff.step ? TMR_W'(STORE_WAIT_CYC)
                                   : TMR_W'(CYC_DESEL_NOSTORE);
        end
      end
      ST_DESEL:
      begin
        if (tmr_done)
        begin
          // Restore step high so the idle level is safe for a reselect.
          nxt_pins.step = 1'b1;
          nxt_done = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Registers; select comes out of reset high, as the device requires.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff <= ST_IDLE;
      cmd_ff <= '0;
      left_ff <= '0;
      pins_ff <= '{sel_n: PIN_SEL_IDLE_N, up: 1'b0,
                   step: PIN_STEP_IDLE};
      pos_ff <= POS_MIN;
      ready_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cmd_ff <= nxt_cmd;
      left_ff <= nxt_left;
      pins_ff <= nxt_pins;
      pos_ff <= nxt_pos;
      ready_ff <= nxt_ready;
      done_ff <= nxt_done;
    end
  end

  // Outputs straight from flip-flops.
  assign o_pins = pins_ff;
  assign o_pos = pos_ff;
  assign o_cmd_ready = ready_ff;
  assign o_done = done_ff;
endmodule : udw_host
`default_nettype wire

// ===== udw_host_assertions.sv
// Checker for the pin sequences of the wiper host.
`timescale 1ns/100ps
`default_nettype none
module udw_host_assertions
  import udw_pkg::*;
#(
  parameter int STORE_WAIT_CYC = CYC_DESEL_STORE
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Watched outputs.
  input wire logic o_cmd_ready,
  input wire logic [POS_W-1:0] o_pos,
  input wire udw_pins_t o_pins
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  logic [31:0] gap_ff;
  logic [31:0] nxt_gap;
  logic sel_q_ff;
  logic nxt_sel_q;
  logic stored_ff;
  logic nxt_stored;
  // Deselected cycles, saturating so a long idle never wraps to zero.
  // Only a storing deselect owes the long wait, so its kind is kept.
  always_comb
  begin
    nxt_gap = 32'h0000_0000;
    nxt_sel_q = o_pins.sel_n;
    nxt_stored = stored_ff;
    if (o_pins.sel_n)
      nxt_gap = (gap_ff == 32'hffff_ffff) ? gap_ff : gap_ff + 32'h0000_0001;
    if (o_pins.sel_n && !sel_q_ff)
      nxt_stored = o_pins.step;
  end
  // Reset counts as a long deselect.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gap_ff <= 32'hffff_ffff;
      sel_q_ff <= 1'b1;
      stored_ff <= 1'b0;
    end
    else
    begin
      gap_ff <= nxt_gap;
      sel_q_ff <= nxt_sel_q;
      stored_ff <= nxt_stored;
    end
  end
  property p_idle;
    o_cmd_ready |-> o_pins.sel_n;
  endproperty
  a_idle: assert property (p_idle) else $error("selected while idle");
  property p_sel;
    $fell(o_pins.sel_n) |-> o_pins.step;
  endproperty
  a_sel: assert property (p_sel) else $error("select with step low");
  property p_step;
    $fell(o_pins.step) |-> !o_pins.sel_n;
  endproperty
  a_step: assert property (p_step) else $error("step while idle");
  property p_nost;
    $rose(o_pins.sel_n) && !o_pins.step |-> ##[1:200] o_pins.step;
  endproperty
  a_nost: assert property (p_nost) else $error("step stuck low");
  property p_gap;
    $fell(o_pins.sel_n) && stored_ff |-> $past(gap_ff) >= STORE_WAIT_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("reselect too soon");
  property p_dir;
    !o_pins.sel_n && !$past(o_pins.sel_n) |-> $stable(o_pins.up);
  endproperty
  a_dir: assert property (p_dir) else $error("direction moved");
  property p_up;
    $fell(o_pins.step) && o_pins.up && $past(o_pos) != POS_MAX
      |-> o_pos == $past(o_pos) + 7'h01;
  endproperty
  a_up: assert property (p_up) else $error("tracked position off");
  property p_down;
    $fell(o_pins.step) && !o_pins.up && $past(o_pos) != POS_MIN
      |-> o_pos == $past(o_pos) - 7'h01;
  endproperty
  a_down: assert property (p_down) else $error("tracked drop off");
  property p_sat;
    $fell(o_pins.step) && o_pins.up && $past(o_pos) == POS_MAX
      |-> o_pos == POS_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("tracked top wrapped");
  c_store: cover property ($rose(o_pins.sel_n) && o_pins.step);
  c_nost: cover property ($rose(o_pins.sel_n) && !o_pins.step);
  c_top: cover property ($fell(o_pins.step) && o_pos == POS_MAX);
endmodule : udw_host_assertions
bind udw_host udw_host_assertions #(.STORE_WAIT_CYC(STORE_WAIT_CYC)) chk_u (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .o_cmd_ready(o_cmd_ready),
  .o_pos(o_pos), .o_pins(o_pins));
`default_nettype wire

// ===== udw_host_bench.sv
// Self-checking bench for the wiper host driving the device model.
`timescale 1ns/100ps
`default_nettype none
module udw_host_bench;
  import udw_pkg::*;
  logic clk;
  logic rst;
  logic cmd_v;
  logic ld;
  logic pwr;
  logic rdy;
  logic done;
  udw_cmd_t cmd;
  udw_pins_t pins;
  logic [POS_W-1:0] pos_i;
  logic [POS_W-1:0] pos;
  logic [POS_W-1:0] dpos;
  logic [POS_W-1:0] dmem;
  logic [127:0] tap;
  int err_total;
  int cmp_count;
  // Store wait kept above the select lead-in, so a short wait shows up.
  udw_host #(.STORE_WAIT_CYC(400)) dut_u (.i_core_clk(clk), .i_rst(rst),
    .i_cmd_valid(cmd_v), .i_cmd(cmd), .o_cmd_ready(rdy), .o_done(done),
    .i_pos_load(ld), .i_pos(pos_i), .o_pos(pos), .o_pins(pins));
  udw_wiper_model dev_u (.i_pwr(pwr), .i_pins(pins), .o_pos(dpos),
    .o_stored(dmem), .o_tap(tap));
  // Free-running core clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic tk();
    @(posedge clk);
    #1;
  endtask : tk
  // Bounded wait for ready (0) or done (1).
  task automatic wt(input bit d);
    int k;
    k = 0;
    while ((d ? done : rdy) !== 1'b1)
    begin
      tk();
      k++;
      if (k > 9000)
      begin
        err_total++;
        $display("ERROR %0t wait ran out", $time);
        finish_test();
      end
    end
  endtask : wt
  task automatic run(input logic up, input logic [7:0] n, input logic st);
    wt(0);
    cmd = '{up, n, st};
    cmd_v = 1'b1;
    tk();
    cmd_v = 1'b0;
    wt(1);
  endtask : run
  task automatic load(input logic [6:0] p);
    wt(0);
    pos_i = p;
    ld = 1'b1;
    tk();
    ld = 1'b0;
  endtask : load
  // Climb past the top and store.
  task automatic t_store();
    load(7'h7d);
    run(1'b1, 8'h04, 1'b1);
    chk(dpos, 7'h7f);
    chk(pos, 7'h7f);
    chk(dmem, 7'h7f);
    chk(tap, 128'h1 << 127);
    $display("t_store finished");
  endtask : t_store
  // Move down and leave without storing.
  task automatic t_nostore();
    run(1'b0, 8'h03, 1'b0);
    chk(dpos, 7'h7c);
    chk(dmem, 7'h7f);
    repeat (20) tk();
    chk(dpos, 7'h7c);
    chk(pos, 7'h7c);
    $display("t_nostore finished");
  endtask : t_nostore
  // Power cycle recalls, then both directions in separate selections.
  task automatic t_power();
    rst = 1'b1;
    pwr = 1'b0;
    repeat (6) tk();
    pwr = 1'b1;
    tk();
    rst = 1'b0;
    chk(dpos, 7'h7f);
    load(7'h7f);
    run(1'b0, 8'h02, 1'b0);
    run(1'b1, 8'h01, 1'b1);
    chk(dpos, 7'h7e);
    chk(dmem, 7'h7e);
    chk(pos, 7'h7e);
    $display("t_power finished");
  endtask : t_power
  // Main sequence; supply rises while the host holds select high.
  initial
  begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    cmd_v = 1'b0;
    ld = 1'b0;
    pos_i = 7'h00;
    cmd = '0;
    pwr = 1'b0;
    #1 pwr = 1'b1;
    repeat (6) tk();
    rst = 1'b0;
    t_store();
    t_nostore();
    t_power();
    finish_test();
  end
endmodule : udw_host_bench
`default_nettype wire

// ===== udw_pkg.sv
// Package of constants and carrier types for the up/down wiper host.
package udw_pkg;
  // Core clock period in picoseconds (125 MHz).
  localparam int CLK_PERIOD_PS = 8000;
  // Timing figures in their own units, as printed.
  localparam int T_SEL_SETUP_NS = 100;
  localparam int T_DIR_SETUP_US = 1;
  localparam int T_STEP_LOW_US = 1;
  localparam int T_STEP_HIGH_US = 1;
  localparam int T_STEP_CYCLE_US = 4;
  localparam int T_STEP_TO_DESEL_US = 1;
  localparam int T_DESEL_STORE_MS = 20;
  localparam int T_DESEL_NOSTORE_US = 1;
  // Least times rounded up to whole cycles.
  localparam int CYC_SEL_SETUP =
    (T_SEL_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_DIR_SETUP =
    (T_DIR_SETUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_STEP_LOW =
    (T_STEP_LOW_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // High phase stretched so that low plus high meets the cycle time.
  localparam int CYC_STEP_HIGH_MIN =
    (T_STEP_HIGH_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_STEP_CYCLE =
    (T_STEP_CYCLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_STEP_HIGH =
    (CYC_STEP_CYCLE - CYC_STEP_LOW > CYC_STEP_HIGH_MIN) ?
    CYC_STEP_CYCLE - CYC_STEP_LOW : CYC_STEP_HIGH_MIN;
  localparam int CYC_STEP_TO_DESEL =
    (T_STEP_TO_DESEL_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CYC_DESEL_NOSTORE =
    (T_DESEL_NOSTORE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam longint CYC_DESEL_STORE_L =
    (longint'(T_DESEL_STORE_MS) * 1000000000 + CLK_PERIOD_PS - 1) /
    CLK_PERIOD_PS;
  localparam int CYC_DESEL_STORE = int'(CYC_DESEL_STORE_L);
  // Width of the timing counter and of the step-count field.
  localparam int TMR_W = 22;
  localparam int STEPS_W = 8;
  // Device position range: seven-bit counter, taps 0 to 127.
  localparam int POS_W = 7;
  localparam logic [POS_W-1:0] POS_MAX = 7'h7f;
  localparam logic [POS_W-1:0] POS_MIN = 7'h00;
  // Pin levels at reset: deselected, step high.
  localparam logic PIN_SEL_IDLE_N = 1'b1;
  localparam logic PIN_STEP_IDLE = 1'b1;

  // Command from user logic: move by a number of steps, then store if asked or if steps is zero.
  typedef struct packed {
    logic up;
    logic [STEPS_W-1:0] steps;
    logic store;
  } udw_cmd_t;

  // The three pins driven to the device.
  typedef struct packed {
    logic sel_n;
    logic up;
    logic step;
  } udw_pins_t;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SEL,
    ST_DIR,
    ST_LOW,
    ST_HIGH,
    ST_ENDPHASE,
    ST_DESEL
  } udw_state_t;
endpackage : udw_pkg

// ===== udw_timer.sv
// Down-counting wait timer with a one-cycle done pulse.
`timescale 1ns/100ps
`default_nettype none
module udw_timer
  import udw_pkg::*;
#(
  parameter int W = TMR_W
)
(
  // Clock and reset.
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Load a count; done pulses when it has run out.
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  output logic o_done
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  logic run_ff;
  logic nxt_run;
  logic done_ff;
  logic nxt_done;

  // A load restarts the count; at one the done pulse is raised.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_done = 1'b0;
    if (i_load)
    begin
      nxt_cnt = i_count;
      nxt_run = 1'b1;
    end
    else if (run_ff)
    begin
      if (cnt_ff <= W'(1))
      begin
        nxt_run = 1'b0;
        nxt_done = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff - W'(1);
      end
    end
  end

  // Registers of the timer.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      done_ff <= nxt_done;
    end
  end

  assign o_done = done_ff;
endmodule : udw_timer
`default_nettype wire

// ===== udw_wiper_model.sv
// Behavioural model of the up/down wiper device.
`timescale 1ns/100ps
`default_nettype none
module udw_wiper_model
  import udw_pkg::*;
#(
  parameter logic [POS_W-1:0] INIT = 7'h7d
)
(
  // Supply and pins.
  input wire logic i_pwr,
  input wire udw_pins_t i_pins,
  // Wiper state.
  output logic [POS_W-1:0] o_pos,
  output logic [POS_W-1:0] o_stored,
  output logic [127:0] o_tap
);
  // Saturating move, so the ends never wrap.
  function automatic logic [POS_W-1:0] nudge(input logic [POS_W-1:0] p,
    input logic up);
    if (up)
      return (p == POS_MAX) ? p : p + 7'h01;
    return (p == POS_MIN) ? p : p - 7'h01;
  endfunction : nudge
  initial o_stored = INIT;
  // Supply rise recalls the stored tap; nothing else moves it unselected.
  always @(posedge i_pwr) o_pos = o_stored;
  // Steps count only while selected.
  always @(negedge i_pins.step)
    if (i_pwr && !i_pins.sel_n) o_pos = nudge(o_pos, i_pins.up);
  // Selecting with step low also moves one tap.
  always @(negedge i_pins.sel_n)
    if (i_pwr && !i_pins.step) o_pos = nudge(o_pos, i_pins.up);
  // Deselect stores only with step high, then sits in standby.
  always @(posedge i_pins.sel_n)
    if (i_pwr && i_pins.step) o_stored = o_pos;
  // Exactly one tap switch is on.
  assign o_tap = 128'h1 << o_pos;
endmodule : udw_wiper_model
`default_nettype wire
